// ===== pkg/hbd_pkg.sv
// Constants, types and field layout of the buffer descriptor engine
// Functional notes
// - Descriptor bit 31 clear: engine owns the buffer and fills it.
// - Held descriptor with polling allowed: stay idle, re-read it periodically.
// - Transparent mode: a held descriptor deactivates the channel instead.
// - Held descriptor with polling inhibited: wait for a channel activate.
// - End-of-buffer event only when the descriptor enables it.
// - Never take more octets than buffer_length; fewer is allowed.
// - When enabled, status word overwrites the descriptor after the buffer.
// - Status word holds owner, end_of_message, length; receive adds error code.
// - Finished transmit writes owner 0, finished receive writes owner 1.
// - Transmit status copies end_of_message from the transmit descriptor.
// - Transmit status length is the count of octets sent.
// - Receive end_of_message set on closing flag or error termination.
// - Error codes: 0,1,2,8,9,10,11,12; other values reserved.
// - Code 1 when the internal receive buffer overflows.
// - Code 2 when frame sync disagrees with the flywheel.
// - Code 8 when the frame loss input is asserted.
// - Code 9 on checksum mismatch of a properly flagged frame.
// - Code 10 when bit count is not octet aligned; beats checksum.
// - Code 11 when the message ends in an abort sequence.
// - Code 12 on overlength, stop the message and hunt for flags.
// - Per-direction inhibit bits suppress the status write-back.
package hbd_pkg;
   localparam int CLK_MHZ   = 250;
   localparam int POLL_NS   = 2000;
   localparam int POLL_CYC  = (POLL_NS * CLK_MHZ + 999) / 1000;
   localparam int FRAME_CYC = 193;

   // Register byte offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_RXD   = 8'h04;
   localparam logic [7:0] A_TXD   = 8'h08;
   localparam logic [7:0] A_MAXL  = 8'h0c;
   localparam logic [7:0] A_STAT  = 8'h10;
   localparam logic [7:0] A_LAST  = 8'h14;

   // Control bits and reset values
   localparam int C_RXEN   = 0;
   localparam int C_TRANSP = 1;
   localparam int C_INH_RX = 2;
   localparam int C_INH_TX = 3;
   localparam int C_ACT    = 4;
   localparam logic [3:0]  CTRL_RST = 4'h0;
   localparam logic [13:0] MAXL_RST = 14'h2000;

   // Descriptor and status word fields
   localparam int B_OWN    = 31;
   localparam int B_NOPOLL = 30;
   localparam int B_EOM    = 29;
   localparam int B_EOB_EN = 28;
   localparam int ERR_LSB  = 16;
   localparam int LEN_W    = 14;

   // Receive error codes
   localparam logic [3:0] E_NONE = 4'h0;
   localparam logic [3:0] E_OVR  = 4'h1;
   localparam logic [3:0] E_FRAME_ALIGNMENT_CHANGE = 4'h2;
   localparam logic [3:0] E_OOF  = 4'h8;
   localparam logic [3:0] E_FCS  = 4'h9;
   localparam logic [3:0] E_ALN  = 4'ha;
   localparam logic [3:0] E_ABT  = 4'hb;
   localparam logic [3:0] E_LNG  = 4'hc;

   // Error flag vector positions
   localparam int F_OVR  = 0;
   localparam int F_FRAME_ALIGNMENT_CHANGE = 1;
   localparam int F_OOF  = 2;
   localparam int F_ABT  = 3;
   localparam int F_FCS  = 4;
   localparam int F_ALN  = 5;
   localparam int F_LNG  = 6;
   localparam int F_W    = 7;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_FETCH  = 3'b001,
      S_ACTIVE = 3'b011,
      S_WBACK  = 3'b010,
      S_POLL   = 3'b110,
      S_TXWB   = 3'b100
   } hbd_state_t;
endpackage

// ===== pkg/hbd_stat_if.sv
// Status word fields passed from the engine to the formatter
interface hbd_stat_if;
   logic                      is_rx;
   logic                      end_of_message;
   logic [hbd_pkg::LEN_W-1:0] len;
   logic [hbd_pkg::F_W-1:0]   err;
   logic [3:0]                code;
   logic [31:0]               word;
   modport eng (output is_rx, end_of_message, len, err, input code, word);
   modport fmt (input is_rx, end_of_message, len, err, output code, word);
endinterface

// ===== src/hbd_status_fmt.sv
// Buffer status word formatter with receive error priority
module hbd_status_fmt (
   hbd_stat_if.fmt s
);
   logic [3:0]  rx_code;
   logic [14:0] mid;

   // First flag found wins; alignment is tested ahead of checksum
   assign rx_code = s.err[hbd_pkg::F_OVR]  ? hbd_pkg::E_OVR  :
                    s.err[hbd_pkg::F_FRAME_ALIGNMENT_CHANGE] ? hbd_pkg::E_FRAME_ALIGNMENT_CHANGE :
                    s.err[hbd_pkg::F_OOF]  ? hbd_pkg::E_OOF  :
                    s.err[hbd_pkg::F_LNG]  ? hbd_pkg::E_LNG  :
                    s.err[hbd_pkg::F_ABT]  ? hbd_pkg::E_ABT  :
                    s.err[hbd_pkg::F_ALN]  ? hbd_pkg::E_ALN  :
                    s.err[hbd_pkg::F_FCS]  ? hbd_pkg::E_FCS  :
                    hbd_pkg::E_NONE;

   // Transmit words carry no error field
   assign s.code = s.is_rx ? rx_code : hbd_pkg::E_NONE;
   assign mid    = s.is_rx ? {9'h000, s.code, 2'b00} : 15'h0000;
   // Owner bit follows direction: set in receive words, clear in transmit words
   assign s.word = {s.is_rx, 1'b0, s.end_of_message, mid, s.len};
endmodule

// ===== src/hbd_engine.sv
// Receive descriptor engine with status write-back and AHB-Lite slave
module hbd_engine #(
   parameter int POLL_CYCLES  = hbd_pkg::POLL_CYC,
   parameter int FRAME_CYCLES = hbd_pkg::FRAME_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        rx_octet_valid,
   output logic             rx_octet_ready,
   input  wire logic        rx_flag_end,
   input  wire logic        rx_abort,
   input  wire logic        rx_fcs_bad,
   input  wire logic        rx_bits_odd,
   input  wire logic        rx_overrun,
   input  wire logic        rx_frame_sync,
   input  wire logic        rx_frame_loss_input,
   output logic             rx_hunt,
   output logic             end_of_buffer_event,
   output logic             chan_active,
   input  wire logic        tx_done,
   input  wire logic        tx_eom_in,
   input  wire logic [13:0] tx_len_in
);
   hbd_stat_if stat ();

   hbd_pkg::hbd_state_t st_r;
   hbd_pkg::hbd_state_t st_nxt;
   hbd_pkg::hbd_state_t after;
   logic [3:0]  ctrl_r;
   logic        go_r;
   logic [31:0] rxd_r;
   logic [31:0] txd_r;
   logic [13:0] maxl_r;
   logic [31:0] last_r;
   logic [31:0] desc_r;
   logic [13:0] cnt_r;
   logic [13:0] msg_r;
   logic [6:0]  err_r;
   logic        eom_r;
   logic        tx_pend_r;
   logic        tx_eom_r;
   logic [13:0] tx_len_r;
   logic        ret_r;
   logic [15:0] poll_r;
   logic [15:0] fly_r;
   logic [2:0]  sy_r;
   logic [2:0]  lo_r;
   logic        wp_r;
   logic [7:0]  wa_r;
   logic        take_go;
   logic        deact;

   hbd_status_fmt u_fmt (
      .s (stat.fmt)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and frame flywheel
   wire sy_edge   = sy_r[1] & ~sy_r[2];
   wire oof_edge  = lo_r[1] & ~lo_r[2];
   wire fly_zero  = (fly_r == 16'h0000);
   wire frame_alignment_change_evt  = sy_edge && !fly_zero;

   // Pins are asynchronous; bit 0 feeds bit 1 only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sy_r <= 3'h0;
         lo_r <= 3'h0;
      end else begin
         sy_r <= {sy_r[1:0], rx_frame_sync};
         lo_r <= {lo_r[1:0], rx_frame_loss_input};
      end
   end

   // Sync pulse away from the flywheel wrap is an alignment change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fly_r <= 16'h0000;
      end else if (sy_edge || fly_zero) begin
         fly_r <= 16'(FRAME_CYCLES - 1);
      end else begin
         fly_r <= fly_r - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY
   wire        ap      = hsel && htrans[1] && hready;
   wire        wr_ctrl = wp_r && (wa_r == hbd_pkg::A_CTRL);
   wire        wr_rxd  = wp_r && (wa_r == hbd_pkg::A_RXD);
   wire        wr_txd  = wp_r && (wa_r == hbd_pkg::A_TXD);
   wire        wr_maxl = wp_r && (wa_r == hbd_pkg::A_MAXL);
   wire [31:0] ctrl_rd = {21'h0, st_r, 3'h0, go_r, ctrl_r};
   wire [31:0] stat_rd = {11'h0, err_r, cnt_r};
   wire [7:0]  ra      = haddr[7:0];
   wire [31:0] rd_w    = (ra == hbd_pkg::A_CTRL) ? ctrl_rd :
                         (ra == hbd_pkg::A_RXD)  ? rxd_r :
                         (ra == hbd_pkg::A_TXD)  ? txd_r :
                         (ra == hbd_pkg::A_MAXL) ? {18'h0, maxl_r} :
                         (ra == hbd_pkg::A_STAT) ? stat_rd :
                         (ra == hbd_pkg::A_LAST) ? last_r : 32'h0;

   // Address phase captured; write data lands one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r      <= 1'b0;
         wa_r      <= 8'h00;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wp_r <= ap && hwrite;
         if (ap) begin
            wa_r <= haddr[7:0];
         end
         if (ap && !hwrite) begin
            hrdata <= rd_w;
         end
      end
   end

   // Software registers; a write beats a same-cycle deactivation
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= hbd_pkg::CTRL_RST;
         rxd_r  <= 32'h0;
         txd_r  <= 32'h0;
         maxl_r <= hbd_pkg::MAXL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= hwdata[3:0];
         end else if (deact) begin
            ctrl_r[hbd_pkg::C_RXEN] <= 1'b0;
         end
         if (wr_rxd) begin
            rxd_r <= hwdata;
         end
         if (wr_txd) begin
            txd_r <= hwdata;
         end
         if (wr_maxl) begin
            maxl_r <= hwdata[13:0];
         end
      end
   end

   // Activate request and transmit status pending; set beats clear
   wire go_set = wr_ctrl && hwdata[hbd_pkg::C_ACT];
   wire tx_set = tx_done && !ctrl_r[hbd_pkg::C_INH_TX];
   wire tx_clr = (st_r == hbd_pkg::S_TXWB) && mem_ack;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         go_r      <= 1'b0;
         tx_pend_r <= 1'b0;
         tx_eom_r  <= 1'b0;
         tx_len_r  <= 14'h0;
      end else begin
         go_r      <= go_set || (go_r && !take_go);
         tx_pend_r <= tx_set || (tx_pend_r && !tx_clr);
         if (tx_set) begin
            tx_eom_r <= tx_eom_in;
            tx_len_r <= tx_len_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer decisions
   wire        rxen      = ctrl_r[hbd_pkg::C_RXEN];
   wire        inh_rx    = ctrl_r[hbd_pkg::C_INH_RX];
   wire        in_act    = (st_r == hbd_pkg::S_ACTIVE);
   wire        fetch_ack = (st_r == hbd_pkg::S_FETCH) && mem_ack;
   wire        held      = mem_rdata[hbd_pkg::B_OWN];
   wire        nopoll    = mem_rdata[hbd_pkg::B_NOPOLL];
   wire [13:0] buffer_length      = desc_r[13:0];
   wire        acc       = rx_octet_valid && rx_octet_ready;
   wire        over      = acc && (msg_r >= maxl_r);
   wire        acc_ok    = acc && !over;
   wire [13:0] cnt_inc   = cnt_r + 14'h0001;
   wire        full      = acc_ok && (cnt_inc == buffer_length);
   wire        err_end   = rx_overrun || oof_edge || frame_alignment_change_evt;
   wire        msg_end   = rx_flag_end || rx_abort || err_end || over;
   wire        fin       = in_act && (full || msg_end);
   wire        mem_op    = (st_r == hbd_pkg::S_FETCH) ||
                           (st_r == hbd_pkg::S_WBACK) ||
                           (st_r == hbd_pkg::S_TXWB);
   wire [6:0]  err_set   = {over, rx_flag_end && rx_bits_odd,
                            rx_flag_end && rx_fcs_bad, rx_abort,
                            oof_edge, frame_alignment_change_evt, rx_overrun};
   wire [13:0] cnt_nxt   = fetch_ack ? 14'h0 :
                           (in_act && acc_ok) ? cnt_inc : cnt_r;
   wire [13:0] buffer_length_nxt  = fetch_ack ? mem_rdata[13:0] : buffer_length;

   assign after = rxen ? hbd_pkg::S_FETCH : hbd_pkg::S_IDLE;

   // Channel sequencer
   always_comb begin
      st_nxt  = st_r;
      take_go = 1'b0;
      deact   = 1'b0;
      unique case (st_r)
         hbd_pkg::S_IDLE: begin
            if (tx_pend_r) begin
               st_nxt = hbd_pkg::S_TXWB;
            end else if (go_r && rxen) begin
               st_nxt  = hbd_pkg::S_FETCH;
               take_go = 1'b1;
            end
         end
         hbd_pkg::S_FETCH: begin
            if (mem_ack) begin
               if (!held) begin
                  st_nxt = hbd_pkg::S_ACTIVE;
               end else if (ctrl_r[hbd_pkg::C_TRANSP]) begin
                  st_nxt = hbd_pkg::S_IDLE;
                  deact  = 1'b1;
               end else if (nopoll) begin
                  st_nxt = hbd_pkg::S_IDLE;
               end else begin
                  st_nxt = hbd_pkg::S_POLL;
               end
            end
         end
         hbd_pkg::S_ACTIVE: begin
            if (fin) begin
               st_nxt = inh_rx ? after : hbd_pkg::S_WBACK;
            end
         end
         hbd_pkg::S_WBACK: begin
            if (mem_ack) begin
               st_nxt = after;
            end
         end
         hbd_pkg::S_POLL: begin
            if (!rxen) begin
               st_nxt = hbd_pkg::S_IDLE;
            end else if (tx_pend_r) begin
               st_nxt = hbd_pkg::S_TXWB;
            end else if (poll_r == 16'h0000) begin
               st_nxt = hbd_pkg::S_FETCH;
            end
         end
         hbd_pkg::S_TXWB: begin
            if (mem_ack) begin
               st_nxt = ret_r ? hbd_pkg::S_FETCH : hbd_pkg::S_IDLE;
            end
         end
         default: st_nxt = hbd_pkg::S_IDLE;
      endcase
   end

   // State, poll timer and return point after a transmit write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r   <= hbd_pkg::S_IDLE;
         poll_r <= 16'h0;
         ret_r  <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_r != hbd_pkg::S_POLL) begin
            poll_r <= 16'(POLL_CYCLES - 1);
         end else if (poll_r != 16'h0000) begin
            poll_r <= poll_r - 16'h0001;
         end
         if (st_r != hbd_pkg::S_TXWB) begin
            ret_r <= (st_r == hbd_pkg::S_POLL);
         end
      end
   end

   // Buffer counters and latched end-of-buffer status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         desc_r <= 32'h0;
         cnt_r  <= 14'h0;
         msg_r  <= 14'h0;
         err_r  <= 7'h0;
         eom_r  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (fetch_ack) begin
            desc_r <= mem_rdata;
            err_r  <= 7'h0;
         end else if (in_act) begin
            err_r <= err_r | err_set;
         end
         if (fin && msg_end) begin
            msg_r <= 14'h0;
         end else if (in_act && acc_ok) begin
            msg_r <= msg_r + 14'h0001;
         end
         if (fin) begin
            eom_r <= msg_end;
         end
      end
   end

   // Status word fields for the formatter
   assign stat.is_rx = (st_r != hbd_pkg::S_TXWB);
   assign stat.end_of_message   = stat.is_rx ? eom_r : tx_eom_r;
   assign stat.len   = stat.is_rx ? cnt_r : tx_len_r;
   assign stat.err   = err_r;

   ////////////////////////////////////////////////////////////////////////
   // Memory master and block outputs; request rises a cycle into a state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_req             <= 1'b0;
         mem_we              <= 1'b0;
         mem_addr            <= 32'h0;
         mem_wdata           <= 32'h0;
         last_r              <= 32'h0;
         rx_octet_ready      <= 1'b0;
         rx_hunt             <= 1'b0;
         end_of_buffer_event <= 1'b0;
         chan_active         <= 1'b0;
      end else begin
         mem_req   <= mem_op && !mem_ack;
         mem_we    <= (st_r != hbd_pkg::S_FETCH);
         mem_addr  <= (st_r == hbd_pkg::S_TXWB) ? txd_r : rxd_r;
         mem_wdata <= stat.word;
         if ((st_r == hbd_pkg::S_WBACK) && mem_ack) begin
            last_r <= mem_wdata;
         end
         // Ready drops before the buffer could overflow
         rx_octet_ready <= (st_nxt == hbd_pkg::S_ACTIVE) &&
                           (cnt_nxt < buffer_length_nxt);
         rx_hunt <= in_act && over;
         end_of_buffer_event <= fin && desc_r[hbd_pkg::B_EOB_EN];
         chan_active <= (st_nxt == hbd_pkg::S_ACTIVE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_held_poll;
      fetch_ack && held && !nopoll && !ctrl_r[hbd_pkg::C_TRANSP];
   endsequence

   sequence s_poll_done;
      (st_r == hbd_pkg::S_POLL) && (poll_r == 16'h0000) && rxen &&
      !tx_pend_r;
   endsequence

   a_owned_starts:
   assert property (fetch_ack && !held |=> in_act && cnt_r == 14'h0)
      else $error("owned descriptor did not start the buffer");

   a_held_polls:
   assert property (s_held_poll |=> st_r == hbd_pkg::S_POLL)
      else $error("held descriptor did not enter polling");

   a_poll_refetch:
   assert property (s_poll_done |=> st_r == hbd_pkg::S_FETCH ##1 mem_req)
      else $error("poll expiry did not re-read descriptor");

   a_transp_deact:
   assert property (fetch_ack && held && ctrl_r[hbd_pkg::C_TRANSP] &&
                    !wr_ctrl |=> !rxen && st_r == hbd_pkg::S_IDLE)
      else $error("transparent channel not deactivated");

   a_nopoll_waits:
   assert property ((st_r == hbd_pkg::S_IDLE) && !go_r && !tx_pend_r
                    |=> st_r == hbd_pkg::S_IDLE)
      else $error("idle channel left without activate");

   a_eob_gated:
   assert property (end_of_buffer_event |->
                    $past(fin) && $past(desc_r[hbd_pkg::B_EOB_EN]))
      else $error("end of buffer event without enable");

   a_len_capped:
   assert property (in_act |-> cnt_r <= buffer_length)
      else $error("octet count passed buffer length");

   a_rx_writeback:
   assert property (fin && !inh_rx |=>
                    st_r == hbd_pkg::S_WBACK ##1 mem_req && mem_we)
      else $error("receive status not written back");

   a_rx_owner:
   assert property (mem_req && st_r == hbd_pkg::S_WBACK |->
                    mem_wdata[hbd_pkg::B_OWN] && mem_addr == rxd_r)
      else $error("receive status owner bit not set");

   a_tx_fields:
   assert property (mem_req && st_r == hbd_pkg::S_TXWB |->
                    !mem_wdata[hbd_pkg::B_OWN] &&
                    mem_wdata[hbd_pkg::B_EOM] == tx_eom_r &&
                    mem_wdata[13:0] == tx_len_r)
      else $error("transmit status word fields wrong");

   a_align_wins:
   assert property (mem_req && st_r == hbd_pkg::S_WBACK &&
                    err_r == 7'h30 |->
                    mem_wdata[19:16] == hbd_pkg::E_ALN)
      else $error("alignment code did not override checksum");

   a_long_stops:
   assert property (in_act && over |=> rx_hunt && !rx_octet_ready &&
                    err_r[hbd_pkg::F_LNG] && eom_r)
      else $error("overlength did not stop the message");

   a_inhibit_skip:
   assert property (fin && inh_rx |=> st_r != hbd_pkg::S_WBACK)
      else $error("status written while inhibited");
endmodule

// ===== verif/hbd_host_mem.sv
// Host descriptor memory that answers the engine's bus master port
module hbd_host_mem (
   input  wire logic        hclk,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  lat,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] words [64];
   int          wait_n = 0;
   // Ack after lat cycles; read data toggles away from stale values
   always @(posedge hclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (wait_n >= int'(lat)) begin
            mem_ack <= 1'b1;
            wait_n <= 0;
            if (mem_we) words[mem_addr[7:2]] <= mem_wdata;
            else mem_rdata <= words[mem_addr[7:2]];
         end else wait_n <= wait_n + 1;
      end
   end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the receive descriptor engine
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        mem_req, mem_we, mem_ack, rx_octet_valid, rx_octet_ready;
   logic        rx_flag_end, rx_abort, rx_fcs_bad, rx_bits_odd, rx_overrun;
   logic        rx_frame_sync, rx_frame_loss_input, rx_hunt;
   logic        end_of_buffer_event, chan_active, tx_done, tx_eom_in, rd_ph;
   logic [13:0] tx_len_in;
   logic [3:0]  lat;
   logic [31:0] exp_q[$];
   int          n_mismatch = 0, n_checks = 0, n_rd = 0, n_eob = 0, cyc = 0;
   int          n_hunt = 0;
   logic [3:0]  codes [6] = '{hbd_pkg::E_OVR, hbd_pkg::E_FCS, hbd_pkg::E_ALN,
                              hbd_pkg::E_ABT, hbd_pkg::E_OOF, hbd_pkg::E_NONE};
   assign hready = hreadyout;
   hbd_engine #(.POLL_CYCLES(8), .FRAME_CYCLES(16)) u_dut (.*);
   hbd_host_mem u_mem (.*);
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang limit
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Oldest note against each result; empty queue means a surprise
   task automatic note(input logic [31:0] seen);
      // Unexpected result always counts, even if it is unknown
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check(seen, exp_q.pop_front());
   endtask
   always @(posedge hclk) begin
      if (rd_ph) note(hrdata);
      if (mem_req && mem_we && mem_ack) note(mem_wdata);
      if (mem_req && !mem_we && mem_ack) n_rd++;
      if (end_of_buffer_event) n_eob++;
      if (rx_hunt) n_hunt++;
      rd_ph <= hsel && htrans[1] && !hwrite && hready;
   end
   // Single AHB transfer, held until hready is seen high
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (!hready);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (!hready);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      ahb(1'b0, a, 32'h0);
   endtask
   task automatic send(input int n);
      rx_octet_valid <= 1'b1;
      while (n > 0) begin
         @(posedge hclk);
         if (rx_octet_ready) n--;
      end
      rx_octet_valid <= 1'b0;
   endtask
   // End of message by kind; frame loss is a level, held a few cycles
   task automatic pulse(input int k);
      rx_overrun <= (k == 0);
      rx_flag_end <= (k inside {1, 2, 5});
      rx_fcs_bad <= (k inside {1, 2});
      rx_bits_odd <= (k == 2);
      rx_abort <= (k == 3);
      rx_frame_loss_input <= (k == 4);
      @(posedge hclk);
      {rx_overrun, rx_flag_end, rx_fcs_bad, rx_bits_odd, rx_abort} <= '0;
      repeat (4) @(posedge hclk);
      rx_frame_loss_input <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int          n;
      logic [13:0] len;
      logic        end_of_message;
      {hsel, hwrite, htrans, haddr, hwdata, rx_octet_valid, rx_flag_end,
       rx_abort, rx_fcs_bad, rx_bits_odd, rx_overrun, rx_frame_sync,
       rx_frame_loss_input, tx_done, tx_eom_in, tx_len_in, rd_ph} = '0;
      hsize = 3'b010;
      lat = 4'h0;
      hresetn = 1'b0;
      void'($urandom(70));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h0c, 32'h0000_2000);
      rd(8'h10, 32'h0);
      rd(8'h18, 32'h0);
      ahb(1'b1, 8'h04, 32'h40);
      ahb(1'b1, 8'h08, 32'h80);
      rd(8'h04, 32'h40);
      u_mem.words[16] = 32'h1000_0004;
      exp_q.push_back(32'h8000_0004);
      ahb(1'b1, 8'h00, 32'h11);
      repeat (50) if (!chan_active) @(posedge hclk);
      send(4);
      repeat (30) @(posedge hclk);
      check(32'(n_eob), 32'h1);
      n = n_rd;
      repeat (40) @(posedge hclk);
      check(32'(n_rd - n >= 2), 32'h1);
      // Transmit status while the receiver polls
      len = 14'($urandom_range(1, 8191));
      end_of_message = 1'($urandom);
      exp_q.push_back({2'b00, end_of_message, 15'h0, len});
      tx_done <= 1'b1;
      tx_eom_in <= end_of_message;
      tx_len_in <= len;
      @(posedge hclk);
      tx_done <= 1'b0;
      repeat (40) @(posedge hclk);
      // Six termination kinds, with a slow or prompt memory
      for (int k = 0; k < 6; k++) begin
         lat <= 4'($urandom_range(0, 3));
         n = $urandom_range(1, 3);
         exp_q.push_back({3'b101, 9'h0, codes[k], 2'b00, 14'(n)});
         u_mem.words[16] = 32'h0000_0010;
         repeat (100) if (!chan_active) @(posedge hclk);
         send(n);
         pulse(k);
         repeat (40) @(posedge hclk);
      end
      check(32'(n_eob), 32'h1);
      // Limit of two octets: the third one ends the message as too long
      ahb(1'b1, 8'h0c, 32'h2);
      exp_q.push_back(32'ha00c_0002);
      u_mem.words[16] = 32'h0000_0010;
      repeat (100) if (!chan_active) @(posedge hclk);
      send(3);
      repeat (40) @(posedge hclk);
      check(32'(n_hunt), 32'h1);
      u_mem.words[16] = 32'hc000_0000;
      repeat (40) @(posedge hclk);
      n = n_rd;
      repeat (40) @(posedge hclk);
      check(32'(n_rd - n), 32'h0);
      u_mem.words[16] = 32'h1000_0002;
      exp_q.push_back(32'h8000_0002);
      ahb(1'b1, 8'h00, 32'h11);
      repeat (50) if (!chan_active) @(posedge hclk);
      send(2);
      repeat (30) @(posedge hclk);
      check(32'(n_eob), 32'h2);
      // Transparent channel meets a held descriptor and shuts itself off
      ahb(1'b1, 8'h00, 32'h3);
      repeat (40) @(posedge hclk);
      rd(8'h00, 32'h2);
      @(posedge hclk);
      check(32'(exp_q.size()), 32'h0);
      conclude();
   end
endmodule
